// ---- inc/vrp_pkg.sv ----
`default_nettype none
package vrp_pkg;

   // Geometry of the marker array
   localparam int ADDR_W_DEF = 10;

   // Timing, figures in ns, counts in cycles of clk_sys
   localparam int CNT_W         = 12;
   localparam int CLK_PERIOD_NS = 50;
   localparam int END_PULSE_NS  = 12500;   // End-of-message pulse width
   localparam int FULL_PULSE_NS = 12500;   // Overflow pulse width
   localparam int INT_SAMPLE_NS = 125000;  // Internal sample period
   localparam int EXT_IDLE_NS   = 20000;   // External clock declared absent after this

   // Least times round up, the idle timeout rounds down
   localparam logic [CNT_W-1:0] END_PULSE_CYC =
      CNT_W'((END_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] FULL_PULSE_CYC =
      CNT_W'((FULL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] INT_SAMPLE_CYC =
      CNT_W'((INT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] EXT_IDLE_CYC = CNT_W'(EXT_IDLE_NS / CLK_PERIOD_NS);

   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;

   // Operating states of the control logic
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b000,
      ST_IDLE    = 3'b001,
      ST_RECORD  = 3'b010,
      ST_PLAY    = 3'b011,
      ST_FULL    = 3'b100
   } vrp_state_e;

endpackage
`default_nettype wire

// ---- rtl/vrp_msg_store.sv ----
`timescale 1ns/100ps
`default_nettype none
module vrp_msg_store #(
   parameter int ADDR_W = vrp_pkg::ADDR_W_DEF
) (
   input  wire logic              clk_sys,
   input  wire logic              wrEn,
   input  wire logic [ADDR_W-1:0] wrAddr,
   input  wire logic              wrMark,
   input  wire logic [ADDR_W-1:0] rdAddr,
   output logic                   rdMark
);
   import vrp_pkg::*;

   // One marker bit per location; no reset, the markers stand for nonvolatile cells
   logic markMem [2**ADDR_W];

   // Markers change only when a recording writes the location
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         markMem[wrAddr] <= wrMark;
      end
   end

   // Read is combinational so the pointer step sees the marker at once
   assign rdMark = markMem[rdAddr];

endmodule
`default_nettype wire

// ---- rtl/vrp_sample_clock.sv ----
`timescale 1ns/100ps
`default_nettype none
module vrp_sample_clock #(
   parameter logic [vrp_pkg::CNT_W-1:0] INT_CYC  = vrp_pkg::INT_SAMPLE_CYC,
   parameter logic [vrp_pkg::CNT_W-1:0] IDLE_CYC = vrp_pkg::EXT_IDLE_CYC
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic xclkLvl,
   output logic      sampleTick,
   output logic      extInUse
);
   import vrp_pkg::*;

   logic             xPrev_r;
   logic             halfT_r;
   logic [CNT_W-1:0] idleCnt_r;
   logic [CNT_W-1:0] intCnt_r;
   logic             xRise;
   logic             intTick;

   assign xRise    = xclkLvl & ~xPrev_r;
   assign extInUse = (idleCnt_r < IDLE_CYC);
   assign intTick  = (intCnt_r == INT_CYC - CNT_ONE);

   // Halve the external clock so its duty cycle does not matter
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         xPrev_r <= 1'b0;
         halfT_r <= 1'b0;
      end else begin
         xPrev_r <= xclkLvl;
         if (xRise) begin
            halfT_r <= ~halfT_r; // R14
         end
      end
   end

   // Activity watch, saturates so a stopped clock falls back to internal
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         idleCnt_r <= IDLE_CYC;
      end else if (xRise) begin
         idleCnt_r <= CNT_ZERO;
      end else if (idleCnt_r < IDLE_CYC) begin
         idleCnt_r <= idleCnt_r + CNT_ONE;
      end
   end

   // Internal sample timer stands in for the trimmed oscillator
   always_ff @(posedge clk_sys) begin
      if (rst || intTick) begin
         intCnt_r <= CNT_ZERO;
      end else begin
         intCnt_r <= intCnt_r + CNT_ONE;
      end
   end

   // External clock wins whenever it is running
   assign sampleTick = extInUse ? (xRise & halfT_r) : intTick; // R12

endmodule
`default_nettype wire

// ---- rtl/vrp_core.sv ----
// Summary of operation
// [R1] Overflow flag pulses low at array end
// [R2] Overflow flag then follows enable until power-down
// [R3] Operations only while enable input is low
// [R4] Address and mode latched at enable fall
// [R5] Power-down high keeps device in standby
// [R6] Power-down returns pointer to first location
// [R7] Marker written right after each recording; none is written when a recording ends at array end
// [R8] Marker kept until recorded over
// [R9] Message-end flag pulses low fixed width
// [R10] Low supply: flag low, playback only
// [R11] Button mode: flag high while busy
// [R12] Internal sample clock unless external supplied
// [R13] High selects playback, low selects record
// [R14] External sample clock halved on entry
// [R15] At array end stop until power-down
// [R16] Cascade: overflow drives next enable
`timescale 1ns/100ps
`default_nettype none
module vrp_core #(
   parameter int                        ADDR_W         = vrp_pkg::ADDR_W_DEF,
   parameter logic [vrp_pkg::CNT_W-1:0] INT_SAMPLE_CYC = vrp_pkg::INT_SAMPLE_CYC,
   parameter logic [vrp_pkg::CNT_W-1:0] EXT_IDLE_CYC   = vrp_pkg::EXT_IDLE_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              opEnable_n,
   input  wire logic              power_down_ctl,
   input  wire logic              playNotRecord,
   input  wire logic [ADDR_W-1:0] startAddr,
   input  wire logic              external_sample_clock,
   input  wire logic              supplyLow,
   input  wire logic              button_driven_mode,
   output logic                   memory_full_flag,
   output logic                   message_end_flag,
   output logic [ADDR_W-1:0]      ptrAddr,
   output logic                   recordActive,
   output logic                   playActive,
   output logic                   standbyActive,
   output logic                   extClockInUse
);
   import vrp_pkg::*;

   localparam int LO_W = 4 + ADDR_W;
   localparam logic [ADDR_W-1:0] ADDR_LAST = {ADDR_W{1'b1}};
   localparam logic [ADDR_W-1:0] ADDR_FIRST = '0;

   // Synchroniser stages; enable and power-down idle high, the rest low
   logic [1:0]      hiSyncA_r;
   logic [1:0]      hiSyncB_r;
   logic [LO_W-1:0] loSyncA_r;
   logic [LO_W-1:0] loSyncB_r;

   logic              ceS;
   logic              pdS;
   logic              prS;
   logic              supLowS;
   logic              btnS;
   logic              xclkS;
   logic [ADDR_W-1:0] addrS;
   logic              cePrev_r;
   logic              ceFall;

   vrp_state_e        state_r;
   vrp_state_e        state_nxt;
   logic [ADDR_W-1:0] ptr_r;
   logic              lock_r;
   logic              followCe_r;
   logic [CNT_W-1:0]  eomCnt_r;
   logic [CNT_W-1:0]  ovfCnt_r;

   logic              sampleTick;
   logic              extInUse;
   logic              markHere;
   logic              atLast;
   logic              endRec;
   logic              recStep;
   logic              playStep;
   logic              msgEnd;
   logic              hitFull;
   logic              advance;
   logic              busy;

   logic              memFull_r;
   logic              memFull_nxt;
   logic              msgEnd_r;
   logic              msgEnd_nxt;
   logic              recAct_r;
   logic              playAct_r;
   logic              stby_r;
   logic              extUse_r;

   // Two flops on every pin before any logic reads it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hiSyncA_r <= 2'h3;
         hiSyncB_r <= 2'h3;
         loSyncA_r <= '0;
         loSyncB_r <= '0;
      end else begin
         hiSyncA_r <= {opEnable_n, power_down_ctl};
         hiSyncB_r <= hiSyncA_r;
         loSyncA_r <= {playNotRecord, supplyLow, button_driven_mode,
                       external_sample_clock, startAddr};
         loSyncB_r <= loSyncA_r;
      end
   end

   assign ceS     = hiSyncB_r[1];
   assign pdS     = hiSyncB_r[0];
   assign prS     = loSyncB_r[LO_W-1];
   assign supLowS = loSyncB_r[LO_W-2];
   assign btnS    = loSyncB_r[LO_W-3];
   assign xclkS   = loSyncB_r[LO_W-4];
   assign addrS   = loSyncB_r[ADDR_W-1:0];

   // Falling edge of the enable starts an operation
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cePrev_r <= 1'b1;
      end else begin
         cePrev_r <= ceS;
      end
   end

   assign ceFall = cePrev_r & ~ceS; // R4

   // Sample timing source
   vrp_sample_clock #(
      .INT_CYC  (INT_SAMPLE_CYC),
      .IDLE_CYC (EXT_IDLE_CYC)
   ) u_sample_clock (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .xclkLvl    (xclkS),
      .sampleTick (sampleTick),
      .extInUse   (extInUse)
   );

   // Per-location end markers
   vrp_msg_store #(
      .ADDR_W (ADDR_W)
   ) u_msg_store (
      .clk_sys (clk_sys),
      .wrEn    (recStep | endRec),
      .wrAddr  (ptr_r),
      .wrMark  (endRec),
      .rdAddr  (ptr_r),
      .rdMark  (markHere)
   );

   // Step decisions; all of them wait for a sample tick except the record end
   assign atLast   = (ptr_r == ADDR_LAST);
   assign endRec   = (state_r == ST_RECORD) && (pdS || ceS || lock_r); // R3 R7
   assign recStep  = (state_r == ST_RECORD) && !endRec && sampleTick; // R8
   assign playStep = (state_r == ST_PLAY) && !pdS && !ceS && sampleTick; // R3
   assign msgEnd   = playStep && markHere;
   assign hitFull  = (recStep || (playStep && !markHere)) && atLast; // R1
   assign advance  = (recStep || (playStep && !markHere)) && !atLast;
   assign busy     = (state_r == ST_RECORD) || (state_r == ST_PLAY);

   // Next state of the operation sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_STANDBY: begin
            if (!pdS) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (pdS) begin
               state_nxt = ST_STANDBY; // R5
            end else if (ceFall && prS) begin
               state_nxt = ST_PLAY; // R13
            end else if (ceFall && !lock_r) begin
               state_nxt = ST_RECORD; // R13 R10
            end
         end
         ST_RECORD: begin
            if (pdS) begin
               state_nxt = ST_STANDBY;
            end else if (endRec) begin
               state_nxt = ST_IDLE;
            end else if (hitFull) begin
               state_nxt = ST_FULL;
            end
         end
         ST_PLAY: begin
            if (pdS) begin
               state_nxt = ST_STANDBY;
            end else if (ceS || msgEnd) begin
               state_nxt = ST_IDLE;
            end else if (hitFull) begin
               state_nxt = ST_FULL;
            end
         end
         ST_FULL: begin
            if (pdS) begin
               state_nxt = ST_STANDBY; // R15
            end
         end
         default: begin
            state_nxt = ST_STANDBY;
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= ST_STANDBY;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Address pointer; held at the array end until power-down clears it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ptr_r <= ADDR_FIRST;
      end else if (pdS) begin
         ptr_r <= ADDR_FIRST; // R6
      end else if (state_r == ST_IDLE && ceFall && (prS || !lock_r)) begin
         ptr_r <= addrS; // R4
      end else if (advance) begin
         ptr_r <= ptr_r + 1'b1; // R15
      end
   end

   // Supply lockout is sticky; only a reset restores recording
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lock_r <= 1'b0;
      end else if (supLowS) begin
         lock_r <= 1'b1; // R10
      end
   end

   // End-of-message pulse timer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         eomCnt_r <= CNT_ZERO;
      end else if (msgEnd) begin
         eomCnt_r <= END_PULSE_CYC; // R9
      end else if (eomCnt_r != CNT_ZERO) begin
         eomCnt_r <= eomCnt_r - CNT_ONE;
      end
   end

   // Overflow pulse timer and follow mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ovfCnt_r   <= CNT_ZERO;
         followCe_r <= 1'b0;
      end else begin
         if (hitFull) begin
            ovfCnt_r <= FULL_PULSE_CYC; // R1
         end else if (ovfCnt_r != CNT_ZERO) begin
            ovfCnt_r <= ovfCnt_r - CNT_ONE;
         end
         // Set wins over the power-down clear
         if (hitFull) begin
            followCe_r <= 1'b1; // R2
         end else if (pdS) begin
            followCe_r <= 1'b0; // R2
         end
      end
   end

   // Overflow pin: pulse first, then the enable level for cascading
   always_comb begin
      if (ovfCnt_r != CNT_ZERO) begin
         memFull_nxt = 1'b0; // R1
      end else if (followCe_r) begin
         memFull_nxt = ceS; // R2 R16
      end else begin
         memFull_nxt = 1'b1;
      end
   end

   // Message-end pin; low supply outranks the button-mode indicator
   always_comb begin
      if (lock_r) begin
         msgEnd_nxt = 1'b0; // R10
      end else if (btnS) begin
         msgEnd_nxt = busy; // R11
      end else begin
         msgEnd_nxt = (eomCnt_r == CNT_ZERO); // R9
      end
   end

   // Registered outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         memFull_r <= 1'b1;
         msgEnd_r  <= 1'b1;
         recAct_r  <= 1'b0;
         playAct_r <= 1'b0;
         stby_r    <= 1'b1;
         extUse_r  <= 1'b0;
      end else begin
         memFull_r <= memFull_nxt;
         msgEnd_r  <= msgEnd_nxt;
         recAct_r  <= (state_r == ST_RECORD);
         playAct_r <= (state_r == ST_PLAY);
         stby_r    <= (state_r == ST_STANDBY); // R5
         extUse_r  <= extInUse; // R12
      end
   end

   assign memory_full_flag = memFull_r;
   assign message_end_flag = msgEnd_r;
   assign ptrAddr          = ptr_r;
   assign recordActive     = recAct_r;
   assign playActive       = playAct_r;
   assign standbyActive    = stby_r;
   assign extClockInUse    = extUse_r;

endmodule
`default_nettype wire

// ---- tb/vrp_core_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module vrp_core_asserts #(
   parameter int ADDR_W = vrp_pkg::ADDR_W_DEF
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              opEnable_n,
   input wire logic              power_down_ctl,
   input wire logic              playNotRecord,
   input wire logic              supplyLow,
   input wire logic              button_driven_mode,
   input wire logic              memory_full_flag,
   input wire logic              message_end_flag,
   input wire logic [ADDR_W-1:0] ptrAddr,
   input wire logic              recordActive,
   input wire logic              playActive,
   input wire logic              standbyActive
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Named steps; s_fullFall is shared by three properties, s_btnBusy serves one
   sequence s_fullFall;
      $fell(memory_full_flag);
   endsequence
   sequence s_btnBusy;
      (button_driven_mode && !supplyLow)[*5] ##0 (playActive && $past(playActive));
   endsequence
   // Pulse widths checked over the first cycles only, to keep unrolling small
   property p_fullPulse;
      s_fullFall |-> !memory_full_flag[*8];
   endproperty
   property p_fullFollow;
      s_fullFall ##251 (opEnable_n && !power_down_ctl)[*5] |-> memory_full_flag;
   endproperty
   property p_runNeedsEn;
      $rose(recordActive || playActive) |-> !opEnable_n;
   endproperty
   property p_playSel;
      $rose(playActive) |-> playNotRecord;
   endproperty
   property p_recSel;
      $rose(recordActive) |-> !playNotRecord;
   endproperty
   property p_standby;
      power_down_ctl[*6] |-> standbyActive && !recordActive && !playActive;
   endproperty
   property p_ptrHome;
      power_down_ctl[*6] |-> ptrAddr == '0;
   endproperty
   property p_fullHold;
      s_fullFall |=> $stable(ptrAddr)[*8];
   endproperty
   property p_endPulse;
      $fell(message_end_flag) && !supplyLow && !button_driven_mode |-> !message_end_flag[*8];
   endproperty
   property p_lowSupply;
      supplyLow[*5] |-> !message_end_flag && !$rose(recordActive);
   endproperty
   property p_btnBusy;
      s_btnBusy |-> message_end_flag;
   endproperty
   a_fullPulse: assert property (p_fullPulse) else $error("overflow pulse short");
   a_fullFollow: assert property (p_fullFollow) else $error("overflow not following");
   a_runNeedsEn: assert property (p_runNeedsEn) else $error("run without enable");
   a_playSel: assert property (p_playSel) else $error("play with select low");
   a_recSel: assert property (p_recSel) else $error("record with select high");
   a_standby: assert property (p_standby) else $error("busy in power-down");
   a_ptrHome: assert property (p_ptrHome) else $error("pointer not home");
   a_fullHold: assert property (p_fullHold) else $error("pointer moved when full");
   a_endPulse: assert property (p_endPulse) else $error("end pulse short");
   a_lowSupply: assert property (p_lowSupply) else $error("low supply ignored");
   a_btnBusy: assert property (p_btnBusy) else $error("busy lamp off");
endmodule
bind vrp_core vrp_core_asserts #(.ADDR_W(ADDR_W)) u_chk (
   .clk_sys, .rst, .opEnable_n, .power_down_ctl, .playNotRecord, .supplyLow,
   .button_driven_mode, .memory_full_flag, .message_end_flag, .ptrAddr,
   .recordActive, .playActive, .standbyActive
);
`default_nettype wire

// ---- tb/vrp_ctl_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module vrp_ctl_model #(
   parameter int ADDR_W = 4
) (
   input  wire logic              clk_sys,
   output logic                   opEnable_n,
   output logic                   power_down_ctl,
   output logic                   playNotRecord,
   output logic [ADDR_W-1:0]      startAddr,
   output logic                   external_sample_clock
);
   // Idle controller: disabled, powered down, clock pin pulled low
   initial begin
      opEnable_n = 1'h1;
      power_down_ctl = 1'h1;
      playNotRecord = 1'h0;
      startAddr = '0;
      external_sample_clock = 1'h0;
   end
   // Select and address settle a cycle before the enable falls
   task automatic start(input logic pnr, input logic [ADDR_W-1:0] a);
      @(posedge clk_sys);
      playNotRecord <= pnr;
      startAddr <= a;
      @(posedge clk_sys);
      opEnable_n <= 1'h0;
   endtask
   task automatic stop();
      @(posedge clk_sys);
      opEnable_n <= 1'h1;
   endtask
   // Power-down only while idle or after an overflow
   task automatic pdown(input logic v);
      @(posedge clk_sys);
      power_down_ctl <= v;
      repeat (4) @(posedge clk_sys);
   endtask
   // Burst of an even edge count, so the pin rests low afterwards
   task automatic xburst(input int n);
      repeat (2 * n) begin
         @(posedge clk_sys);
         external_sample_clock <= ~external_sample_clock;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/vrp_core_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module vrp_core_tb;
   import vrp_pkg::*;
   localparam int AW = 4;
   logic          clk_sys, rst, supplyLow, button_driven_mode;
   logic          opEnable_n, power_down_ctl, playNotRecord, external_sample_clock;
   logic [AW-1:0] startAddr, ptrAddr, ptrEnd;
   logic          memory_full_flag, message_end_flag, recordActive, playActive;
   logic          standbyActive, extClockInUse;
   int            fails = 0, num_checks = 0, cyc = 0, i;

   vrp_core #(.ADDR_W(AW), .INT_SAMPLE_CYC(12'h008), .EXT_IDLE_CYC(12'h010)) dut (
      .clk_sys, .rst, .opEnable_n, .power_down_ctl, .playNotRecord, .startAddr,
      .external_sample_clock, .supplyLow, .button_driven_mode, .memory_full_flag,
      .message_end_flag, .ptrAddr, .recordActive, .playActive, .standbyActive,
      .extClockInUse
   );
   vrp_ctl_model #(.ADDR_W(AW)) ctl (
      .clk_sys, .opEnable_n, .power_down_ctl, .playNotRecord, .startAddr,
      .external_sample_clock
   );

   task automatic chk(input logic [AW-1:0] seen, input logic [AW-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Land just after the edge so registered outputs have settled
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Record on the external clock; halving gives one step per two rises
   task automatic t_external_sample_clock();
      ctl.pdown(1'h0);
      fork
         ctl.xburst(16);
         ctl.start(1'h0, 4'h5);
      join
      cyc_n(4);
      chk(extClockInUse, 1'h1);
      chk(ptrAddr, 4'hd);
      ctl.stop();
      cyc_n(30);
      chk(extClockInUse, 1'h0);
      $display("test external_sample_clock done");
   endtask
   task automatic t_recPlay();
      ctl.pdown(1'h0);
      ctl.start(1'h0, 4'h2);
      cyc_n(8);
      chk(recordActive, 1'h1);
      cyc_n(8);
      ctl.stop();
      cyc_n(8);
      chk(recordActive, 1'h0);
      ptrEnd = ptrAddr;
      ctl.start(1'h1, 4'h2);
      for (i = 0; i < 200 && message_end_flag !== 1'h0; i++) cyc_n(1);
      chk(message_end_flag, 1'h0);
      chk(ptrAddr, ptrEnd);
      cyc_n(240);
      chk(message_end_flag, 1'h0);
      cyc_n(15);
      chk(message_end_flag, 1'h1);
      chk(playActive, 1'h0);
      ctl.stop();
      $display("test record/play done");
   endtask
   task automatic t_button();
      @(posedge clk_sys);
      button_driven_mode <= ~button_driven_mode;
      cyc_n(6);
      chk(message_end_flag, 1'h0);
      ctl.start(1'h1, 4'h2);
      cyc_n(6);
      chk(message_end_flag, 1'h1);
      ctl.stop();
      cyc_n(30);
      chk(message_end_flag, 1'h0);
      @(posedge clk_sys);
      button_driven_mode <= ~button_driven_mode;
      cyc_n(6);
      $display("test button done");
   endtask
   // Overflow: pulse, follow mode, then power-down recovery
   task automatic t_overflow();
      ctl.start(1'h0, 4'he);
      for (i = 0; i < 100 && memory_full_flag !== 1'h0; i++) cyc_n(1);
      chk(memory_full_flag, 1'h0);
      chk(ptrAddr, 4'hf);
      cyc_n(8);
      chk(recordActive, 1'h0);
      cyc_n(230);
      ctl.stop();
      cyc_n(20);
      chk(memory_full_flag, 1'h1);
      ctl.start(1'h0, 4'h3);
      cyc_n(10);
      chk(memory_full_flag, 1'h0);
      chk(recordActive, 1'h0);
      chk(ptrAddr, 4'hf);
      ctl.pdown(1'h1);
      cyc_n(4);
      chk(ptrAddr, 4'h0);
      chk(standbyActive, 1'h1);
      ctl.stop();
      cyc_n(6);
      chk(memory_full_flag, 1'h1);
      $display("test overflow done");
   endtask
   // Lock is sticky, so this runs last
   task automatic t_supply();
      ctl.pdown(1'h0);
      @(posedge clk_sys);
      supplyLow <= ~supplyLow;
      cyc_n(6);
      chk(message_end_flag, 1'h0);
      ctl.start(1'h0, 4'h2);
      cyc_n(8);
      chk(recordActive, 1'h0);
      ctl.stop();
      cyc_n(4);
      ctl.start(1'h1, 4'h2);
      cyc_n(8);
      chk(playActive, 1'h1);
      ctl.stop();
      $display("test supply done");
   endtask

   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Hang guard, far beyond the thousand or so cycles the tests need
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      rst = 1'h1;
      supplyLow = 1'h0;
      button_driven_mode = 1'h0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'h0;
      cyc_n(3);
      chk(memory_full_flag, 1'h1);
      chk(message_end_flag, 1'h1);
      chk(ptrAddr, 4'h0);
      chk(standbyActive, 1'h1);
      chk(extClockInUse, 1'h0);
      $display("test reset done");
      t_external_sample_clock();
      t_recPlay();
      t_button();
      t_overflow();
      t_supply();
      wrap_up();
   end
endmodule
`default_nettype wire
